// file: src/lkrq_link_req.sv
/*
 * lkrq_link_req: link-side request encoder. Takes commands from the
 * link core, times bus requests against the PHY control lines, sends
 * frames on the request pin and collects status for register reads.
 * Assumes ctl_i and d_i are driven by the PHY synchronously to clk_i
 * (the PHY supplies that clock), and that rx_ack_i, crc_error_i and
 * tx_active_i come from the link's own logic on the same clock.
 */
`timescale 1ns/1ps
module lkrq_link_req
    import lkrq_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // command port from link core
    input  wire logic        cmd_valid_i,
    input  wire logic [2:0]  cmd_type_i,
    input  wire logic [1:0]  cmd_speed_i,
    input  wire logic [3:0]  cmd_addr_i,
    input  wire logic [7:0]  cmd_data_i,
    input  wire logic        cmd_accel_i,
    output logic             cmd_ready_o,
    // link core side information
    input  wire logic        rx_ack_i,
    input  wire logic        crc_error_i,
    input  wire logic        tx_active_i,
    // PHY interface
    input  wire logic [1:0]  ctl_i,
    input  wire logic [1:0]  d_i,
    output logic             lreq_o,
    // results to link core
    output logic             grant_o,
    output logic             bus_pending_o,
    output logic             rd_done_o,
    output logic [3:0]       rd_addr_o,
    output logic [7:0]       rd_data_o,
    output logic             sub_gap_o,
    output logic             bus_reset_o,
    output logic             accel_on_o
);
    lkrq_state_t s_r;
    lkrq_state_t s_nxt;
    logic        ser_busy;

    lkrq_req_ser u_ser (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (s_r.ld),
        .frame_i (s_r.frame),
        .len_i   (s_r.len),
        .busy_o  (ser_busy),
        .lreq_o  (lreq_o)
    );

    function automatic logic [3:0] sat_inc(input logic [3:0] c);
        return (c == CNT_SAT) ? c : c + 4'h1;
    endfunction : sat_inc

    always_comb begin
        logic rx_on;
        logic rx_win;
        logic tx_win;
        logic idle_ok;
        logic ser_free;
        logic win_ok;
        logic fp_typ;
        rx_on    = 1'b0;
        rx_win   = 1'b0;
        tx_win   = 1'b0;
        idle_ok  = 1'b0;
        ser_free = 1'b0;
        win_ok   = 1'b0;
        fp_typ   = 1'b0;

        s_nxt         = s_r;
        s_nxt.ld      = 1'b0;
        s_nxt.grant   = 1'b0;
        s_nxt.rd_done = 1'b0;
        s_nxt.gap     = 1'b0;
        s_nxt.bres    = 1'b0;

        // receive and transmit windows
        rx_on  = ctl_i == CTL_RX;
        rx_win = rx_on || s_r.rx_cnt <= RX_WIN;
        tx_win = tx_active_i || s_r.tx_cnt <= TX_WIN;
        s_nxt.rx_cnt     = rx_on ? 4'h0 : sat_inc(s_r.rx_cnt);
        s_nxt.tx_cnt     = tx_active_i ? 4'h0 : sat_inc(s_r.tx_cnt);
        s_nxt.ctl_idle_d = ctl_i == CTL_IDLE;
        idle_ok = s_r.ctl_idle_d && ctl_i == CTL_IDLE;

        // status capture, two bits a cycle, first bits S0 S1
        if (ctl_i == CTL_STS) begin
            s_nxt.sts_on = 1'b1;
            if (s_r.sts_cnt < STS_FULL) begin
                s_nxt.sts_sh[{s_r.sts_cnt[2:0], 1'b0}] = d_i[0];
                s_nxt.sts_sh[{s_r.sts_cnt[2:0], 1'b1}] = d_i[1];
                s_nxt.sts_cnt = s_r.sts_cnt + 4'h1;
            end
        end else if (s_r.sts_on) begin
            // a cut-short read simply waits for the repeat from bit 0
            s_nxt.sts_on  = 1'b0;
            s_nxt.sts_cnt = 4'h0;
            if (s_r.sts_cnt >= STS_SHORT) begin
                s_nxt.gap  = s_r.sts_sh[STS_GAP];
                s_nxt.bres = s_r.sts_sh[STS_BRES];
            end
            if (s_r.sts_cnt == STS_FULL && s_r.rd_out) begin
                s_nxt.rd_out  = 1'b0;
                s_nxt.rd_done = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    s_nxt.rd_addr[3 - i] = s_r.sts_sh[STS_ADDR + i];
                end
                for (int i = 0; i < 8; i++) begin
                    s_nxt.rd_data[7 - i] = s_r.sts_sh[STS_DATA + i];
                end
            end
        end

        // pending bus request tracking
        fp_typ = s_r.bus_typ == TYP_FAIR || s_r.bus_typ == TYP_PRI;
        case (s_r.st)
            ST_PEND, ST_REISSUE: begin
                if (s_nxt.bres) begin
                    s_nxt.st      = ST_IDLE;
                    s_nxt.abandon = 1'b0;
                end else if (ctl_i == CTL_GRANT) begin
                    // abandoned ack gets no grant, so no data follows
                    s_nxt.st      = ST_IDLE;
                    s_nxt.grant   = !s_r.abandon;
                    s_nxt.abandon = 1'b0;
                end else if (s_nxt.gap && !fp_typ) begin
                    s_nxt.st      = ST_IDLE;
                    s_nxt.abandon = 1'b0;
                end else if (rx_on && fp_typ &&
                             !(s_r.accel_on && rx_ack_i)) begin
                    s_nxt.st = ST_REISSUE;
                end
                if (s_r.st == ST_PEND && s_r.bus_typ == TYP_IMM &&
                    crc_error_i && s_nxt.st != ST_IDLE) begin
                    s_nxt.abandon = 1'b1;
                end
            end
            ST_IDLE: begin
                s_nxt.abandon = 1'b0;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // frame issue; a reissue goes ahead of new commands
        ser_free = !ser_busy && !s_r.ld;
        if (ser_free) begin
            if (s_r.st == ST_REISSUE && s_nxt.st == ST_REISSUE &&
                idle_ok) begin
                s_nxt.ld    = 1'b1;
                s_nxt.frame = build_frame(s_r.bus_typ, s_r.bus_spd,
                                          4'h0, 8'h00, 1'b0);
                s_nxt.len   = LEN_BUS;
                s_nxt.st    = ST_PEND;
            end else if (s_r.slot_full) begin
                case (s_r.s_typ)
                    TYP_IMM:  win_ok = rx_win;
                    TYP_ISO:  win_ok = rx_win || tx_win;
                    default:  win_ok = idle_ok;
                endcase
                if (s_r.s_typ == TYP_RSVD ||
                    (is_bus(s_r.s_typ) && s_r.s_spd == SPD_RSVD)) begin
                    s_nxt.slot_full = 1'b0;
                end else if (is_bus(s_r.s_typ)) begin
                    if (s_r.st == ST_IDLE && s_nxt.st == ST_IDLE &&
                        win_ok) begin
                        s_nxt.st        = ST_PEND;
                        s_nxt.bus_typ   = s_r.s_typ;
                        s_nxt.bus_spd   = s_r.s_spd;
                        s_nxt.abandon   = 1'b0;
                        s_nxt.ld        = 1'b1;
                        s_nxt.slot_full = 1'b0;
                    end
                end else if (s_r.s_typ != TYP_READ || !s_r.rd_out) begin
                    s_nxt.ld        = 1'b1;
                    s_nxt.slot_full = 1'b0;
                    if (s_r.s_typ == TYP_READ) begin
                        s_nxt.rd_out = 1'b1;
                    end
                    if (s_r.s_typ == TYP_ACC) begin
                        s_nxt.accel_on = s_r.s_acc;
                    end
                end
                if (s_nxt.ld) begin
                    s_nxt.frame = build_frame(s_r.s_typ, s_r.s_spd,
                                              s_r.s_addr, s_r.s_data,
                                              s_r.s_acc);
                    s_nxt.len   = frame_len(s_r.s_typ);
                end
            end
        end

        // single command slot; ready only when it is empty
        if (s_r.cmd_ready && cmd_valid_i) begin
            s_nxt.slot_full = 1'b1;
            s_nxt.s_typ     = cmd_type_i;
            s_nxt.s_spd     = cmd_speed_i;
            s_nxt.s_addr    = cmd_addr_i;
            s_nxt.s_data    = cmd_data_i;
            s_nxt.s_acc     = cmd_accel_i;
        end
        s_nxt.cmd_ready = !s_nxt.slot_full;
        s_nxt.pend      = s_nxt.st != ST_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r        <= '0;
            // windows start closed so nothing is sent blind after reset
            s_r.rx_cnt <= CNT_SAT;
            s_r.tx_cnt <= CNT_SAT;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready_o   = s_r.cmd_ready;
    assign grant_o       = s_r.grant;
    assign bus_pending_o = s_r.pend;
    assign rd_done_o     = s_r.rd_done;
    assign rd_addr_o     = s_r.rd_addr;
    assign rd_data_o     = s_r.rd_data;
    assign sub_gap_o     = s_r.gap;
    assign bus_reset_o   = s_r.bres;
    assign accel_on_o    = s_r.accel_on;

endmodule : lkrq_link_req

// file: src/lkrq_pkg.sv
/*
 * lkrq_pkg: constants, codes and state types for the link-side request
 * encoder that drives the serial request pin of a serial-bus PHY.
 * Assumes everything runs on the PHY-supplied system clock.
 */
// Notes on behaviour
// - frames are 6 (accel), 7 (bus), 9 (read), 17 (write) bits long.
// - link shifts one bit per clock, ending each frame with zero stop bit.
// - bus request: start bit0, type bits1-3, speed bits4-5, stop bit6.
// - speed 00=100M, 01=200M, 10=400M, 11 reserved.
// - read frame: start, read type, address bits4-7, stop bit8.
// - write frame: start, write type, address 4-7, data 8-15, stop 16.
// - accel frame: flag at bit4, stop bit5; 0 disables, 1 enables.
// - type codes 000 imm, 001 iso, 010 pri, 011 fair, 100-110 reg/accel.
// - fair or priority request starts only after two idle control cycles in a row.
// - receive during or after fair/priority cancels it; link reissues.
// - iso request only in receive or 4 after, transmit or 8 after.
// - immediate request only during reception or within 4 cycles after.
// - crc error abandons pending immediate request; no data on grant.
// - no new register read before the previous one has completed.
package lkrq_pkg;

    // frame lengths including start and stop bit
    localparam logic [4:0] LEN_ACC   = 5'h06;
    localparam logic [4:0] LEN_BUS   = 5'h07;
    localparam logic [4:0] LEN_READ  = 5'h09;
    localparam logic [4:0] LEN_WRITE = 5'h11;
    localparam int         FRAME_W   = 17;

    // request type codes
    localparam logic [2:0] TYP_IMM   = 3'h0;
    localparam logic [2:0] TYP_ISO   = 3'h1;
    localparam logic [2:0] TYP_PRI   = 3'h2;
    localparam logic [2:0] TYP_FAIR  = 3'h3;
    localparam logic [2:0] TYP_READ  = 3'h4;
    localparam logic [2:0] TYP_WRITE = 3'h5;
    localparam logic [2:0] TYP_ACC   = 3'h6;
    localparam logic [2:0] TYP_RSVD  = 3'h7;

    // speed codes
    localparam logic [1:0] SPD_100   = 2'h0;
    localparam logic [1:0] SPD_200   = 2'h1;
    localparam logic [1:0] SPD_400   = 2'h2;
    localparam logic [1:0] SPD_RSVD  = 2'h3;

    // control line codes driven by the PHY
    localparam logic [1:0] CTL_IDLE  = 2'h0;
    localparam logic [1:0] CTL_STS   = 2'h1;
    localparam logic [1:0] CTL_RX    = 2'h2;
    localparam logic [1:0] CTL_GRANT = 2'h3;

    // request windows after receive and transmit, in clock cycles
    localparam logic [3:0] RX_WIN    = 4'h4;
    localparam logic [3:0] TX_WIN    = 4'h8;
    localparam logic [3:0] CNT_SAT   = 4'hF;

    // status stream: two bits per cycle
    localparam logic [3:0] STS_SHORT = 4'h2;
    localparam logic [3:0] STS_FULL  = 4'h8;
    localparam int         STS_GAP   = 1;
    localparam int         STS_BRES  = 2;
    localparam int         STS_ADDR  = 4;
    localparam int         STS_DATA  = 8;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_PEND    = 2'b01,
        ST_REISSUE = 2'b10
    } lkrq_st_t;

    typedef struct packed {
        lkrq_st_t        st;
        logic [2:0]      bus_typ;
        logic [1:0]      bus_spd;
        logic            abandon;
        logic            rd_out;
        logic            accel_on;
        logic            slot_full;
        logic [2:0]      s_typ;
        logic [1:0]      s_spd;
        logic [3:0]      s_addr;
        logic [7:0]      s_data;
        logic            s_acc;
        logic            ctl_idle_d;
        logic [3:0]      rx_cnt;
        logic [3:0]      tx_cnt;
        logic            sts_on;
        logic [3:0]      sts_cnt;
        logic [15:0]     sts_sh;
        logic            ld;
        logic [16:0]     frame;
        logic [4:0]      len;
        logic            cmd_ready;
        logic            grant;
        logic            rd_done;
        logic [3:0]      rd_addr;
        logic [7:0]      rd_data;
        logic            gap;
        logic            bres;
        logic            pend;
    } lkrq_state_t;

    typedef struct packed {
        logic [16:0]     sh;
        logic [4:0]      cnt;
        logic            lreq;
    } lkrq_ser_t;

    // frame bit n goes out n cycles after the start bit; fields msb first
    function automatic logic [16:0] build_frame(
        input logic [2:0] typ,
        input logic [1:0] spd,
        input logic [3:0] addr,
        input logic [7:0] data,
        input logic       acc
    );
        logic [16:0] f;
        f = '0;
        f[0] = 1'b1;
        f[1] = typ[2];
        f[2] = typ[1];
        f[3] = typ[0];
        if (typ == TYP_ACC) begin
            f[4] = acc;
        end else if (typ == TYP_READ || typ == TYP_WRITE) begin
            for (int i = 0; i < 4; i++) begin
                f[4 + i] = addr[3 - i];
            end
            if (typ == TYP_WRITE) begin
                for (int i = 0; i < 8; i++) begin
                    f[8 + i] = data[7 - i];
                end
            end
        end else begin
            f[4] = spd[1];
            f[5] = spd[0];
        end
        return f;
    endfunction : build_frame

    function automatic logic [4:0] frame_len(input logic [2:0] typ);
        case (typ)
            TYP_READ:  frame_len = LEN_READ;
            TYP_WRITE: frame_len = LEN_WRITE;
            TYP_ACC:   frame_len = LEN_ACC;
            default:   frame_len = LEN_BUS;
        endcase
    endfunction : frame_len

    function automatic logic is_bus(input logic [2:0] typ);
        return typ[2] == 1'b0;
    endfunction : is_bus

endpackage : lkrq_pkg

// file: src/lkrq_req_ser.sv
/*
 * lkrq_req_ser: shifts one request frame out on the request pin,
 * start bit first, one bit per clock.
 * Assumes the loader holds off while busy_o is high.
 */
`timescale 1ns/1ps
module lkrq_req_ser
    import lkrq_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // frame load
    input  wire logic        load_i,
    input  wire logic [16:0] frame_i,
    input  wire logic [4:0]  len_i,
    output logic             busy_o,
    // request pin
    output logic             lreq_o
);
    lkrq_ser_t s_r;
    lkrq_ser_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (load_i) begin
            s_nxt.lreq = frame_i[0];
            s_nxt.sh   = frame_i >> 1;
            s_nxt.cnt  = len_i - 5'h01;
        end else if (s_r.cnt != 5'h00) begin
            s_nxt.lreq = s_r.sh[0];
            s_nxt.sh   = s_r.sh >> 1;
            s_nxt.cnt  = s_r.cnt - 5'h01;
        end else begin
            // line rests low between frames
            s_nxt.lreq = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_o = s_r.cnt != 5'h00;
    assign lreq_o = s_r.lreq;

endmodule : lkrq_req_ser

// file: tb/lkrq_link_req_sva.sv
/* lkrq_link_req_sva: port checks for the link request encoder.
   Assumes one clock domain and a bind onto lkrq_link_req. */
`timescale 1ns/1ps
module lkrq_link_req_sva
    import lkrq_pkg::*;
(
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // command and phy side
    input wire logic       cmd_valid_i,
    input wire logic       cmd_ready_o,
    input wire logic [1:0] ctl_i,
    // results
    input wire logic       grant_o,
    input wire logic       bus_pending_o,
    input wire logic       rd_done_o,
    input wire logic [3:0] rd_addr_o,
    input wire logic [7:0] rd_data_o,
    input wire logic       sub_gap_o,
    input wire logic       bus_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    ready_take_a: assert property (
        cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
        else $error("ready high after take");
    ready_fall_a: assert property (
        $fell(cmd_ready_o) |-> $past(cmd_valid_i))
        else $error("ready fell without a command");
    grant_src_a: assert property (
        grant_o |-> $past(ctl_i) == CTL_GRANT)
        else $error("grant without grant code");
    grant_clr_a: assert property (
        grant_o |-> !bus_pending_o ##1 !grant_o)
        else $error("grant not a pulse or pending kept");
    rd_done_a: assert property (
        rd_done_o |-> $past(ctl_i, 2) == CTL_STS && $past(ctl_i) != CTL_STS)
        else $error("read done not after status end");
    rd_hold_a: assert property (
        !rd_done_o |-> $stable(rd_addr_o) && $stable(rd_data_o))
        else $error("read result moved");
    gap_src_a: assert property (
        sub_gap_o |-> $past(ctl_i, 2) == CTL_STS)
        else $error("gap flag without status");
    bres_src_a: assert property (
        bus_reset_o |-> $past(ctl_i, 2) == CTL_STS)
        else $error("bus reset flag without status");
    rx_keep_a: assert property (
        ctl_i == CTL_RX && $past(ctl_i) == CTL_RX && bus_pending_o
        |=> bus_pending_o)
        else $error("receive dropped the pending request");

    cover property (grant_o);
    cover property (rd_done_o);
    cover property (ctl_i == CTL_RX && bus_pending_o);
endmodule : lkrq_link_req_sva

bind lkrq_link_req lkrq_link_req_sva lkrq_link_req_sva_inst (.*);

// file: tb/lkrq_phy_model.sv
/* lkrq_phy_model: behavioural PHY behind the request pin; decodes
   frames, keeps registers, returns read status, grants requests.
   Assumes it runs on the same clock as the link. */
`timescale 1ns/1ps
module lkrq_phy_model
    import lkrq_pkg::*;
(
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    // link pins
    input  wire logic   lreq_i,
    output logic [1:0]  ctl_o,
    output logic [1:0]  d_o,
    // bench control and view
    input  wire logic   rx_i,
    output logic [16:0] f_o,
    output logic [4:0]  len_o,
    output logic [7:0]  cnt_o
);
    logic [16:0] f;
    logic [4:0]  idx;
    logic [4:0]  len;
    logic        busy;
    logic [7:0]  regs [16];
    logic        rd_p;
    logic        bus_p;
    logic [2:0]  bt;
    logic [3:0]  ra;
    logic        acc;
    logic [1:0]  mode;
    logic [3:0]  k;
    logic        tg;
    logic [15:0] s;
    logic [2:0]  t;

    assign t = {f[1], f[2], f[3]};
    always_comb begin
        s = '0;
        for (int i = 0; i < 4; i++) s[4 + i] = ra[3 - i];
        for (int i = 0; i < 8; i++) s[8 + i] = regs[ra][7 - i];
    end
    // receive hides status and grant; bench keeps it off during reads
    assign ctl_o = rx_i ? CTL_RX : mode == 2'h1 ? CTL_STS :
                   (mode == 2'h2 && k == 4'h7) ? CTL_GRANT : CTL_IDLE;
    // outside status the data lines toggle, never a stale value
    assign d_o = mode == 2'h1 ? {s[2 * k + 1], s[2 * k]} : {tg, ~tg};

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy  <= 1'b0;
            cnt_o <= 8'h00;
            rd_p  <= 1'b0;
            bus_p <= 1'b0;
            acc   <= 1'b0;
            mode  <= 2'h0;
            tg    <= 1'b0;
        end else begin
            tg <= ~tg;
            k  <= k + 4'h1;
            case (mode)
                2'h0: if (!rx_i && (rd_p || bus_p)) begin
                    mode <= rd_p ? 2'h1 : 2'h2;
                    k    <= 4'h0;
                end
                2'h1: if (k == 4'h7) begin
                    mode <= 2'h0;
                    rd_p <= 1'b0;
                end
                default: if (rx_i) begin
                    mode  <= 2'h0;
                    bus_p <= bus_p && !(bt[2:1] == 2'b01 && !acc);
                end else if (k == 4'h7) begin
                    mode  <= 2'h0;
                    bus_p <= 1'b0;
                end
            endcase
            if (!busy) begin
                busy <= lreq_i;
                f    <= 17'h00001;
                idx  <= 5'h01;
            end else begin
                f[idx] <= lreq_i;
                idx    <= idx + 5'h01;
                if (idx == 5'h03) begin
                    case ({f[1], f[2], lreq_i})
                        3'h4:    len <= 5'h09;
                        3'h5:    len <= 5'h11;
                        3'h6:    len <= 5'h06;
                        default: len <= 5'h07;
                    endcase
                end
                if (idx > 5'h03 && idx == len - 5'h01) begin
                    busy  <= 1'b0;
                    f_o   <= f | (17'(lreq_i) << idx);
                    len_o <= len;
                    cnt_o <= cnt_o + 8'h01;
                    if (t == TYP_WRITE)
                        regs[{f[4], f[5], f[6], f[7]}] <= {f[8], f[9],
                            f[10], f[11], f[12], f[13], f[14], f[15]};
                    if (t == TYP_READ) begin
                        rd_p <= 1'b1;
                        ra   <= {f[4], f[5], f[6], f[7]};
                    end
                    if (t == TYP_ACC)
                        acc <= f[4];
                    if (!t[2] && {f[4], f[5]} != SPD_RSVD && !bus_p) begin
                        bus_p <= 1'b1;
                        bt    <= t;
                    end
                end
            end
        end
    end
endmodule : lkrq_phy_model

// file: tb/lkrq_link_req_bench.sv
/* lkrq_link_req_bench: self-checking bench for the request encoder.
   Assumes the PHY model on the far side and a 20 MHz clock. */
`timescale 1ns/1ps
module lkrq_link_req_bench
    import lkrq_pkg::*;
;
    logic        clk, rst_n, cmd_valid, cmd_accel, rx, cmd_ready, lreq;
    logic        grant, bus_pending, rd_done, accel_on;
    logic [2:0]  cmd_type;
    logic [1:0]  cmd_speed, ctl, d;
    logic [3:0]  cmd_addr, rd_addr;
    logic [7:0]  cmd_data, rd_data, f_cnt;
    logic [16:0] f_o;
    logic [4:0]  f_len;
    logic        zero = 1'b0;
    int          error_cnt = 0;
    int          checks_done = 0;

    lkrq_link_req lkrq_link_req_inst (
        .clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid),
        .cmd_type_i(cmd_type), .cmd_speed_i(cmd_speed),
        .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
        .cmd_accel_i(cmd_accel), .cmd_ready_o(cmd_ready),
        .rx_ack_i(zero), .crc_error_i(zero), .tx_active_i(zero),
        .ctl_i(ctl), .d_i(d), .lreq_o(lreq), .grant_o(grant),
        .bus_pending_o(bus_pending), .rd_done_o(rd_done),
        .rd_addr_o(rd_addr), .rd_data_o(rd_data), .sub_gap_o(),
        .bus_reset_o(), .accel_on_o(accel_on));
    lkrq_phy_model lkrq_phy_model_inst (
        .clk_i(clk), .rst_n_i(rst_n), .lreq_i(lreq), .ctl_o(ctl),
        .d_o(d), .rx_i(rx), .f_o(f_o), .len_o(f_len), .cnt_o(f_cnt));

    task automatic cmp(input string nm, input logic [16:0] e,
                       input logic [16:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    function automatic logic [16:0] mk(input logic [2:0] t,
        input logic [1:0] s, input logic [3:0] a, input logic [7:0] v,
        input logic c);
        logic [16:0] e;
        e = 17'h00001;
        {e[1], e[2], e[3]} = t;
        if (t == TYP_ACC)
            e[4] = c;
        else if (t[2]) begin
            {e[4], e[5], e[6], e[7]} = a;
            for (int i = 0; i < 8; i++) e[8 + i] = t[0] & v[7 - i];
        end else
            {e[4], e[5]} = s;
        return e;
    endfunction : mk

    task automatic send(input logic [2:0] t, input logic [1:0] s,
        input logic [3:0] a, input logic [7:0] v, input logic c);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_type  <= t;
        cmd_speed <= s;
        cmd_addr  <= a;
        cmd_data  <= v;
        cmd_accel <= c;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 300);
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : send

    // waits for the next frame and compares bits and length
    task automatic chk(input logic [7:0] n0, input logic [2:0] t,
        input logic [1:0] s, input logic [3:0] a, input logic [7:0] v,
        input logic c, input logic [4:0] el);
        int n;
        n = 0;
        while (f_cnt === n0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        cmp("frame count", {9'h0, n0 + 8'h01}, {9'h0, f_cnt});
        cmp("frame bits", mk(t, s, a, v, c), f_o);
        cmp("frame length", {12'h0, el}, {12'h0, f_len});
    endtask : chk

    task automatic issue(input logic [2:0] t, input logic [1:0] s,
        input logic [3:0] a, input logic [7:0] v, input logic c,
        input logic [4:0] el);
        logic [7:0] n0;
        n0 = f_cnt;
        send(t, s, a, v, c);
        chk(n0, t, s, a, v, c, el);
    endtask : issue

    task automatic wait_ev(input string nm, input bit rd);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((rd ? rd_done : grant) !== 1'b1 && n < 300);
        cmp(nm, 17'h1, {16'h0, rd ? rd_done : grant});
    endtask : wait_ev

    task automatic t_regs;
        issue(TYP_WRITE, 2'h0, 4'hA, 8'h5C, 1'b0, LEN_WRITE);
        issue(TYP_WRITE, 2'h0, 4'h3, 8'hA1, 1'b0, LEN_WRITE);
        issue(TYP_READ, 2'h0, 4'hA, 8'h00, 1'b0, LEN_READ);
        wait_ev("read done", 1'b1);
        cmp("read addr", 17'hA, {13'h0, rd_addr});
        cmp("read data", 17'h5C, {9'h0, rd_data});
        issue(TYP_READ, 2'h0, 4'h3, 8'h00, 1'b0, LEN_READ);
        wait_ev("read done", 1'b1);
        cmp("read data", 17'hA1, {9'h0, rd_data});
        $display("test regs done");
    endtask : t_regs

    task automatic t_accel;
        for (int i = 0; i < 2; i++) begin
            issue(TYP_ACC, 2'h0, 4'h0, 8'h00, ~i[0], LEN_ACC);
            repeat (2) @(negedge clk);
            cmp("accel flag", {16'h0, ~i[0]}, {16'h0, accel_on});
        end
        $display("test accel done");
    endtask : t_accel

    task automatic t_bus;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            rx <= i < 2;
            issue(i[2:0], 2'(i % 3), 4'h0, 8'h00, 1'b0, LEN_BUS);
            @(posedge clk);
            rx <= 1'b0;
            wait_ev("grant", 1'b0);
            cmp("pending", 17'h0, {16'h0, bus_pending});
        end
        $display("test bus done");
    endtask : t_bus

    task automatic t_cancel;
        issue(TYP_FAIR, SPD_400, 4'h0, 8'h00, 1'b0, LEN_BUS);
        @(posedge clk);
        rx <= 1'b1;
        repeat (4) @(negedge clk);
        cmp("pending in rx", 17'h1, {16'h0, bus_pending});
        @(posedge clk);
        rx <= 1'b0;
        chk(f_cnt, TYP_FAIR, SPD_400, 4'h0, 8'h00, 1'b0, LEN_BUS);
        wait_ev("grant", 1'b0);
        $display("test cancel done");
    endtask : t_cancel

    task automatic t_rsvd;
        logic [7:0] n0;
        n0 = f_cnt;
        send(TYP_RSVD, 2'h0, 4'h0, 8'h00, 1'b0);
        send(TYP_FAIR, SPD_RSVD, 4'h0, 8'h00, 1'b0);
        repeat (20) @(negedge clk);
        cmp("dropped frames", {9'h0, n0}, {9'h0, f_cnt});
        cmp("ready", 17'h1, {16'h0, cmd_ready});
        $display("test reserved done");
    endtask : t_rsvd

    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        {cmd_valid, cmd_type, cmd_speed, cmd_addr, cmd_data, cmd_accel,
         rx} = 20'h00000;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs;
        t_accel;
        t_bus;
        t_cancel;
        t_rsvd;
        complete_run;
    end

    // whole run is well under 2000 cycles
    initial begin
        #(50 * 20000);
        error_cnt++;
        $display("watchdog expired");
        complete_run;
    end
endmodule : lkrq_link_req_bench
